// [hw/hams_top.sv]
// The Avalon-MM interface to the registers is this design's own decision.
module hams_top
    import hams_pkg::*;
(
    input wire logic i_core_clk,                 // Core clock.
    input wire logic i_rst_n,                    // Synchronous reset, low.
    input wire logic [7:0] i_avs_address,        // Byte address.
    input wire logic i_avs_read,                 // Read request.
    input wire logic i_avs_write,                // Write request.
    input wire logic [31:0] i_avs_writedata,     // Write data.
    input wire logic [3:0] i_avs_byteenable,     // Byte lanes.
    output logic [31:0] o_avs_readdata,          // Read data.
    output logic o_avs_waitrequest,              // Stall.
    input wire hams_pkg::hams_byte_t i_rx_byte,  // Received frame byte.
    input wire hams_pkg::hams_rx_end_t i_rx_end, // Frame end and flags.
    input wire logic [7:0] i_rx_shift_byte,      // Byte at receive shifter.
    input wire logic i_tx_start,                 // Auto frame start pulse.
    input wire logic i_tx_is_cmd,                // Frame is a command.
    input wire logic i_tx_ready,                 // Sink takes address byte.
    output hams_pkg::hams_byte_t o_tx_addr,      // Address byte out.
    output hams_pkg::hams_byte_t o_status_push,  // Status into queue.
    output logic o_frame_discard,                // Frame dropped pulse.
    output logic o_modulo_128                    // Extended control format.
);

    typedef enum logic [1:0] {TX_IDLE, TX_FIRST, TX_LAST} hams_tx_state_t;

    // ==========================================================
    // Declarations
    // ==========================================================
    logic wait_ff, discard_ff, mod128_ff, cmd_ff;
    logic [31:0] rdata_ff;
    logic [7:0] tx_addr_first_ff, tx_addr_second_ff, mode_ff;
    logic [7:0] rx_high_one_ff, rx_high_two_ff, rx_low_one_ff, rx_low_two_ff;
    logic [11:0] cnt_ff, len_ff;
    logic [7:0] byte0_ff, byte1_ff, pin_ff, status_ff;
    hams_byte_t push_ff, tx_ff, nxt_tx;
    hams_tx_state_t tx_state_ff, nxt_tx_state;

    logic req, ack, wr_en, tx_cr;
    logic [5:0] word_idx;
    logic [7:0] wr_byte, rd_byte, rx_low_one_view, low_byte, status_byte, tx_high;
    logic [1:0] op_sel, ha_code;
    logic is_auto, is_framed, is_transp, is_ext, two_byte, hi_active;
    logic high_hit, low_hit, low_match_flag, addr_ok;
    logic [11:0] min_len, cnt_inc;
    logic too_short, suppress, mismatch, report, frame_valid;

    function automatic logic wr_hit(input logic [5:0] idx, input logic [5:0] at,
                                    input logic en);
        wr_hit = en && (at == idx);
    endfunction

    // ==========================================================
    // Bus slave
    // ==========================================================
    // Every access takes one wait cycle so the read mux has a full
    // cycle and a write lands on the one edge the master completes on.
    assign req = i_avs_read | i_avs_write;
    assign ack = req & wait_ff;
    assign wr_en = i_avs_write & ~wait_ff & i_avs_byteenable[0];
    assign word_idx = i_avs_address[7:2];
    assign wr_byte = i_avs_writedata[7:0];

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            wait_ff <= 1'b1;
            rdata_ff <= 32'h0000_0000;
        end else begin
            wait_ff <= ~ack;
            if (ack && i_avs_read) begin
                rdata_ff <= {24'h00_0000, rd_byte};
            end
        end
    end

    assign rx_low_one_view = is_ext ? pin_ff : (two_byte | mode_ff[ADDR_WIDTH_BIT])
                           ? byte1_ff : byte0_ff;

    assign rd_byte =
        (word_idx == IDX_RX_LOW_ONE) ? ((is_transp | is_ext) ? rx_low_one_view
                                                             : RESET_BYTE) :
        (word_idx == IDX_RX_LEN_LOW) ? len_ff[7:0] :
        (word_idx == IDX_RX_LEN_HIGH) ? {4'h0, len_ff[11:8]} :
        (word_idx == IDX_RX_STATUS) ? status_ff :
        (word_idx == IDX_OP_CTRL) ? mode_ff : RESET_BYTE;

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            tx_addr_first_ff <= RESET_BYTE;
            tx_addr_second_ff <= RESET_BYTE;
            rx_high_one_ff <= RESET_BYTE;
            rx_high_two_ff <= RESET_BYTE;
            rx_low_one_ff <= RESET_BYTE;
            rx_low_two_ff <= RESET_BYTE;
            mode_ff <= RESET_BYTE;
        end else begin
            if (wr_hit(IDX_TX_ADDR_FIRST, word_idx, wr_en)) begin
                tx_addr_first_ff <= wr_byte;
            end
            if (wr_hit(IDX_TX_ADDR_SECOND, word_idx, wr_en)) begin
                tx_addr_second_ff <= wr_byte;
            end
            if (wr_hit(IDX_RX_HIGH_ONE, word_idx, wr_en)) begin
                rx_high_one_ff <= wr_byte;
            end
            if (wr_hit(IDX_RX_HIGH_TWO, word_idx, wr_en)) begin
                rx_high_two_ff <= wr_byte;
            end
            if (wr_hit(IDX_RX_LOW_ONE, word_idx, wr_en)) begin
                rx_low_one_ff <= wr_byte;
            end
            if (wr_hit(IDX_RX_LOW_TWO, word_idx, wr_en)) begin
                rx_low_two_ff <= wr_byte;
            end
            if (wr_hit(IDX_OP_CTRL, word_idx, wr_en)) begin
                mode_ff <= wr_byte;
            end
        end
    end

    // ==========================================================
    // Mode decode
    // ==========================================================
    assign op_sel = {mode_ff[OP_SEL_UPPER_BIT], mode_ff[OP_SEL_LOWER_BIT]};
    assign is_auto = op_sel == OP_AUTO;
    assign is_framed = is_auto | (op_sel == OP_NON_AUTO);
    assign is_transp = op_sel == OP_TRANSPARENT;
    assign is_ext = op_sel == OP_EXT_TRANSPARENT;
    assign two_byte = is_framed & mode_ff[ADDR_WIDTH_BIT];
    assign hi_active = two_byte | (is_transp & mode_ff[ADDR_WIDTH_BIT]);

    // ==========================================================
    // Receive frame tracking and status
    // ==========================================================
    assign cnt_inc = (cnt_ff == MAX_COUNT) ? MAX_COUNT : cnt_ff + 12'h001;
    assign low_byte = two_byte ? byte1_ff : byte0_ff;

    hams_addr_cmp u_cmp (
        .i_high(byte0_ff),
        .i_low(low_byte),
        .i_high_one(rx_high_one_ff),
        .i_high_two(rx_high_two_ff),
        .i_low_one(rx_low_one_ff),
        .i_low_two(rx_low_two_ff),
        .o_ha_code(ha_code),
        .o_high_hit(high_hit),
        .o_low_hit(low_hit),
        .o_low_match_flag(low_match_flag)
    );

    assign min_len = two_byte ? MIN_LEN_16BIT :
                     is_framed ? MIN_LEN_8BIT :
                     hi_active ? MIN_LEN_TRANSP1 : MIN_LEN_TRANSP0;
    assign too_short = cnt_ff < min_len;
    assign suppress = cnt_ff < MIN_REPORT_LEN;
    assign frame_valid = ~i_rx_end.partial & ~too_short;
    assign addr_ok = (~hi_active | high_hit) & (~is_framed | low_hit);
    // Short frames carry no full address, so from MIN_REPORT_LEN bytes on they are reported, not dropped.
    assign mismatch = ~too_short & ~addr_ok;
    assign report = i_rx_end.done & ~suppress & ~mismatch;

    assign status_byte = {frame_valid,
                          i_rx_end.overflow,
                          i_rx_end.crc_ok,
                          i_rx_end.aborted,
                          hi_active ? ha_code : HA_SECOND,
                          two_byte & byte0_ff[CR_BIT],
                          is_framed & low_match_flag};

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            cnt_ff <= RESET_COUNT;
            byte0_ff <= RESET_BYTE;
            byte1_ff <= RESET_BYTE;
        end else if (i_rx_end.done) begin
            cnt_ff <= RESET_COUNT;
        end else if (i_rx_byte.valid) begin
            cnt_ff <= cnt_inc;
            if (cnt_ff == RESET_COUNT) begin
                byte0_ff <= i_rx_byte.data;
            end
            if (cnt_ff == 12'h001) begin
                byte1_ff <= i_rx_byte.data;
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            len_ff <= RESET_COUNT;
            status_ff <= RESET_BYTE;
            push_ff <= '0;
            discard_ff <= 1'b0;
            pin_ff <= RESET_BYTE;
            mod128_ff <= 1'b0;
        end else begin
            push_ff.valid <= report;
            discard_ff <= i_rx_end.done & ~report;
            pin_ff <= i_rx_shift_byte;
            mod128_ff <= is_auto & rx_high_two_ff[MODULO_BIT];
            if (report) begin
                len_ff <= cnt_ff;
                status_ff <= status_byte;
                push_ff.data <= status_byte;
            end
        end
    end

    // ==========================================================
    // Transmit address insertion
    // ==========================================================
    // Polarity one sends commands with C/R one; polarity zero inverts.
    assign tx_cr = ~(cmd_ff ^ rx_high_one_ff[POLARITY_BIT]);
    // The start cycle has no registered frame type yet, so the first byte
    // takes its C/R bit straight from the request.
    assign tx_high = {tx_addr_first_ff[7:2], ~(i_tx_is_cmd ^ rx_high_one_ff[POLARITY_BIT]),
                      tx_addr_first_ff[0]};

    always_comb begin
        nxt_tx_state = tx_state_ff;
        nxt_tx = tx_ff;
        case (tx_state_ff)
            TX_IDLE: begin
                if (i_tx_start && is_auto) begin
                    nxt_tx_state = TX_FIRST;
                    nxt_tx.valid = 1'b1;
                    nxt_tx.data = two_byte ? tx_high :
                                  i_tx_is_cmd ? tx_addr_first_ff :
                                  tx_addr_second_ff;
                end
            end
            TX_FIRST: begin
                if (i_tx_ready && two_byte) begin
                    nxt_tx_state = TX_LAST;
                    nxt_tx.data = tx_addr_second_ff;
                end else if (i_tx_ready) begin
                    nxt_tx_state = TX_IDLE;
                    nxt_tx.valid = 1'b0;
                end
            end
            TX_LAST: begin
                if (i_tx_ready) begin
                    nxt_tx_state = TX_IDLE;
                    nxt_tx.valid = 1'b0;
                end
            end
            default: begin
                nxt_tx_state = TX_IDLE;
                nxt_tx.valid = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            tx_state_ff <= TX_IDLE;
            tx_ff <= '0;
            cmd_ff <= 1'b0;
        end else begin
            tx_state_ff <= nxt_tx_state;
            tx_ff <= nxt_tx;
            if (tx_state_ff == TX_IDLE && i_tx_start) begin
                cmd_ff <= i_tx_is_cmd;
            end
        end
    end

    assign o_avs_readdata = rdata_ff;
    assign o_avs_waitrequest = wait_ff;
    assign o_tx_addr = tx_ff;
    assign o_status_push = push_ff;
    assign o_frame_discard = discard_ff;
    assign o_modulo_128 = mod128_ff;

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_bus_ack;
        !o_avs_waitrequest ##1 o_avs_waitrequest;
    endsequence

    a_bus_one_wait: assert property (req && o_avs_waitrequest |=> s_bus_ack)
        else $error("bus access not acknowledged after one wait cycle");

    a_tx_cr_bit: assert property (
        tx_state_ff == TX_FIRST && two_byte |-> o_tx_addr.data[CR_BIT] == tx_cr)
        else $error("transmitted C/R bit wrong");

    a_tx_ignored_mode: assert property (
        tx_state_ff == TX_IDLE && i_tx_start && !is_auto |=> !o_tx_addr.valid)
        else $error("address inserted outside auto mode");

    a_tx_single_sel: assert property (
        tx_state_ff == TX_IDLE && i_tx_start && is_auto && !two_byte
        |=> o_tx_addr.data == ($past(i_tx_is_cmd) ? tx_addr_first_ff : tx_addr_second_ff))
        else $error("single address byte selection wrong");

    a_len_capture: assert property (
        report |=> len_ff == $past(cnt_ff) && o_status_push.valid)
        else $error("length not captured with status");

    a_short_silent: assert property (
        i_rx_end.done && suppress |=> !o_status_push.valid ##1 !o_status_push.valid)
        else $error("status pushed for suppressed frame");

    a_status_flags: assert property (
        report |=> o_status_push.data[ST_CRC_BIT] == $past(i_rx_end.crc_ok)
                && o_status_push.data[ST_ABORT_BIT] == $past(i_rx_end.aborted)
                && o_status_push.data[ST_OVERFLOW_BIT] == $past(i_rx_end.overflow))
        else $error("status flags do not follow frame end");

    a_status_valid: assert property (
        report && i_rx_end.partial |=> !o_status_push.data[ST_VALID_BIT])
        else $error("partial frame marked valid");

    a_ha_priority: assert property (
        report && hi_active && rx_high_one_ff[7:2] == byte0_ff[7:2]
        |=> o_status_push.data[3:2] == HA_FIRST)
        else $error("first high register match not coded 10");

    a_drop_mismatch: assert property (
        i_rx_end.done && !suppress && mismatch |=> o_frame_discard && !o_status_push.valid)
        else $error("unmatched frame not dropped");

    a_status_held: assert property (
        o_status_push.valid |-> status_ff == o_status_push.data)
        else $error("status register differs from queued status");

endmodule

// [pkg/hams_pkg.sv]
package hams_pkg;

    // ==========================================================
    // Register word indices (byte address is four times these)
    // ==========================================================
    localparam logic [5:0] IDX_TX_ADDR_FIRST = 6'h20;
    localparam logic [5:0] IDX_TX_ADDR_SECOND = 6'h21;
    localparam logic [5:0] IDX_RX_LEN_LOW = 6'h22;
    localparam logic [5:0] IDX_RX_LEN_HIGH = 6'h23;
    localparam logic [5:0] IDX_RX_HIGH_ONE = 6'h24;
    localparam logic [5:0] IDX_RX_HIGH_TWO = 6'h25;
    localparam logic [5:0] IDX_RX_STATUS = 6'h26;
    localparam logic [5:0] IDX_OP_CTRL = 6'h27;
    localparam logic [5:0] IDX_RX_LOW_ONE = 6'h28;
    localparam logic [5:0] IDX_RX_LOW_TWO = 6'h29;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int OP_SEL_UPPER_BIT = 7;
    localparam int OP_SEL_LOWER_BIT = 6;
    localparam int ADDR_WIDTH_BIT = 5;
    localparam int CR_BIT = 1;
    localparam int POLARITY_BIT = 1;
    localparam int MODULO_BIT = 1;
    localparam int ST_VALID_BIT = 7;
    localparam int ST_OVERFLOW_BIT = 6;
    localparam int ST_CRC_BIT = 5;
    localparam int ST_ABORT_BIT = 4;
    localparam int ST_LOW_MATCH_BIT = 0;

    // ==========================================================
    // Reset values, codes and frame limits
    // ==========================================================
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [11:0] RESET_COUNT = 12'h000;
    localparam logic [11:0] MAX_COUNT = 12'hFFF;
    localparam logic [7:0] GROUP_ADDR_A = 8'hFE;
    localparam logic [7:0] GROUP_ADDR_B = 8'hFC;
    localparam logic [1:0] OP_AUTO = 2'h0;
    localparam logic [1:0] OP_NON_AUTO = 2'h1;
    localparam logic [1:0] OP_TRANSPARENT = 2'h2;
    localparam logic [1:0] OP_EXT_TRANSPARENT = 2'h3;
    localparam logic [1:0] HA_FIRST = 2'h2;
    localparam logic [1:0] HA_SECOND = 2'h0;
    localparam logic [1:0] HA_GROUP = 2'h1;
    localparam logic [1:0] HA_NONE = 2'h3;
    localparam logic [11:0] MIN_LEN_16BIT = 12'h004;
    localparam logic [11:0] MIN_LEN_8BIT = 12'h003;
    localparam logic [11:0] MIN_LEN_TRANSP1 = 12'h003;
    localparam logic [11:0] MIN_LEN_TRANSP0 = 12'h002;
    localparam logic [11:0] MIN_REPORT_LEN = 12'h002;

    // ==========================================================
    // Carriers
    // ==========================================================
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } hams_byte_t;

    typedef struct packed {
        logic done;
        logic crc_ok;
        logic aborted;
        logic overflow;
        logic partial;
    } hams_rx_end_t;

endpackage

// [hw/hams_addr_cmp.sv]
module hams_addr_cmp
    import hams_pkg::*;
(
    input wire logic [7:0] i_high,     // Received high address byte.
    input wire logic [7:0] i_low,      // Received low or single byte.
    input wire logic [7:0] i_high_one, // First high match value.
    input wire logic [7:0] i_high_two, // Second high match value.
    input wire logic [7:0] i_low_one,  // First low match value.
    input wire logic [7:0] i_low_two,  // Second low match value.
    output logic [1:0] o_ha_code,      // High match code.
    output logic o_high_hit,           // Any high match.
    output logic o_low_hit,            // Any low match.
    output logic o_low_match_flag      // First low register matched.
);

    // ==========================================================
    // Comparators
    // ==========================================================
    // Bits 1 and 0 of the high byte carry C/R and extension, so
    // they take no part in the comparison.
    logic hit_one;
    logic hit_two;
    logic hit_group;
    logic lo_one;
    logic lo_two;

    assign hit_one = i_high[7:2] == i_high_one[7:2];
    assign hit_two = i_high[7:2] == i_high_two[7:2];
    assign hit_group = (i_high[7:2] == GROUP_ADDR_A[7:2])
                     | (i_high[7:2] == GROUP_ADDR_B[7:2]);
    assign lo_one = i_low == i_low_one;
    assign lo_two = i_low == i_low_two;

    // First register wins, so equal registers never give the second code.
    assign o_ha_code = hit_one ? HA_FIRST :
                       hit_two ? HA_SECOND :
                       hit_group ? HA_GROUP : HA_NONE;
    assign o_high_hit = hit_one | hit_two | hit_group;
    assign o_low_hit = lo_one | lo_two;
    assign o_low_match_flag = lo_one;

endmodule

// [verification/hams_remote.sv]
module hams_remote
    import hams_pkg::*;
(
    input wire logic i_core_clk,                 // Core clock.
    input wire hams_pkg::hams_byte_t i_tx_addr,  // Address byte offered.
    output logic o_tx_ready,                     // Address byte taken.
    output hams_pkg::hams_byte_t o_rx_byte,      // Received frame byte.
    output hams_pkg::hams_rx_end_t o_rx_end      // Frame end and flags.
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // Remote station: paces address bytes, sends frames
    // ==========================================================
    logic slow = 1'b0;
    logic [1:0] cnt = 2'h0;
    initial begin
        o_rx_byte = '0;
        o_rx_end = '0;
    end
    always @(posedge i_core_clk) cnt <= cnt + 2'h1;
    // A slow sink takes one byte in four cycles so the offer must stand.
    assign o_tx_ready = ~slow | (cnt == 2'h3);
    task automatic send(input logic [7:0] h, input logic [7:0] l, input int n,
                        input logic [3:0] fl);
        for (int i = 0; i < n; i++) begin
            @(posedge i_core_clk);
            o_rx_byte <= {1'b1, (i == 0) ? h : (i == 1) ? l : 8'(i)};
        end
        @(posedge i_core_clk);
        // Released data is inverted so that a stale value never matches.
        o_rx_byte <= {1'b0, ~o_rx_byte.data};
        o_rx_end <= {1'b1, fl};
        @(posedge i_core_clk);
        o_rx_end <= '0;
    endtask
endmodule

// [verification/testbench.sv]
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import hams_pkg::*;
    // ==========================================================
    // Signals and instances
    // ==========================================================
    logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, start = 1'b0, cmd = 1'b0;
    logic [7:0] addr = 8'h00, got, pdata;
    logic [31:0] wdata = 32'h0, rdata;
    hams_byte_t rx_byte, tx_addr, push;
    hams_rx_end_t rx_end;
    logic tx_ready, wreq, discard, mod128;
    int n_errors = 0, n_checks = 0, cycles = 0, n_push = 0, n_disc = 0;
    logic [7:0] txq[$];
    localparam logic [15:0] INIT [7] = '{16'h9C20, 16'h9012, 16'h9420, 16'hA055,
                                       16'hA466, 16'h8030, 16'h8477};
    localparam logic [23:0] ROWS [4] = '{24'h1055A9, 24'h2266A2, 24'hFE55A7, 24'hFC66A4};
    hams_top u_dut(.i_core_clk(clk), .i_rst_n(rst_n), .i_avs_address(addr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
        .i_avs_byteenable(4'hF), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
        .i_rx_byte(rx_byte), .i_rx_end(rx_end), .i_rx_shift_byte(8'h5A),
        .i_tx_start(start), .i_tx_is_cmd(cmd), .i_tx_ready(tx_ready),
        .o_tx_addr(tx_addr), .o_status_push(push), .o_frame_discard(discard),
        .o_modulo_128(mod128));
    hams_remote u_peer(.i_core_clk(clk), .i_tx_addr(tx_addr), .o_tx_ready(tx_ready),
        .o_rx_byte(rx_byte), .o_rx_end(rx_end));
    initial forever #10 clk = ~clk;
    // ==========================================================
    // Monitors, timeout and tasks
    // ==========================================================
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (push.valid === 1'b1) begin
            pdata <= push.data;
            n_push++;
        end
        if (discard === 1'b1) n_disc++;
        if (tx_addr.valid === 1'b1 && tx_ready === 1'b1) txq.push_back(tx_addr.data);
        if (cycles == 20000) begin
            n_errors++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checks=%0d errors=%0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= {24'h0, d};
        wr <= w;
        rd <= ~w;
        @(posedge clk);
        while (wreq !== 1'b0) @(posedge clk);
        got = rdata[7:0];
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    // A status byte of zero stands for an expected discard.
    task automatic frame(input logic [7:0] h, l, input int n, input logic [3:0] fl,
                         input logic [7:0] e);
        int p, d;
        p = n_push;
        d = n_disc;
        u_peer.send(h, l, n, fl);
        repeat (4) @(posedge clk);
        chk(8'(e === 8'h00 ? n_disc - d : n_push - p), 8'h01);
        if (e !== 8'h00) chk(pdata, e);
    endtask
    task automatic tx(input logic c, input int n, input logic [7:0] e0, e1);
        txq.delete();
        @(posedge clk);
        start <= 1'b1;
        cmd <= c;
        @(posedge clk);
        start <= 1'b0;
        repeat (20) @(posedge clk);
        chk(8'(txq.size()), 8'(n));
        if (n > 0) chk(txq[0], e0);
        if (n > 1) chk(txq[1], e1);
    endtask
    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        bus(0, 8'h9C, 8'h00);
        chk(got, 8'h00);
        foreach (INIT[i]) bus(1, INIT[i][15:8], INIT[i][7:0]);
        foreach (ROWS[i]) begin
            frame(ROWS[i][23:16], ROWS[i][15:8], 4, 4'h8, ROWS[i][7:0]);
            bus(0, 8'h98, 8'h00);
            chk(got, ROWS[i][7:0]);
            bus(0, 8'h88, 8'h00);
            chk(got, 8'h04);
        end
        frame(8'h10, 8'h55, 4095, 4'h8, 8'hA9);
        bus(0, 8'h8C, 8'h00);
        chk(got, 8'h0F);
        frame(8'h10, 8'h55, 4, 4'h6, 8'hD9);
        frame(8'h10, 8'h55, 4, 4'h9, 8'h29);
        frame(8'h10, 8'h55, 3, 4'h8, 8'h29);
        frame(8'h10, 8'h55, 1, 4'h8, 8'h00);
        frame(8'h44, 8'h55, 4, 4'h8, 8'h00);
        chk(8'(mod128), 8'h00);
        bus(1, 8'h94, 8'h22);
        repeat (2) @(posedge clk);
        chk(8'(mod128), 8'h01);
        u_peer.slow = 1'b1;
        for (int k = 0; k < 4; k++) begin
            bus(1, 8'h90, {6'h04, k[1], 1'b0});
            tx(k[0], 2, {6'h0C, k[0] == k[1], 1'b0}, 8'h77);
        end
        bus(1, 8'h90, 8'h00);
        bus(1, 8'h9C, 8'h00);
        tx(1, 1, 8'h30, 8'h00);
        tx(0, 1, 8'h77, 8'h00);
        frame(8'h66, 8'h11, 3, 4'h8, 8'hA0);
        bus(0, 8'hA0, 8'h00);
        chk(got, 8'h00);
        bus(1, 8'h9C, 8'h40);
        repeat (2) @(posedge clk);
        chk(8'(mod128), 8'h00);
        tx(1, 0, 8'h00, 8'h00);
        bus(1, 8'h9C, 8'hA0);
        frame(8'h22, 8'h11, 3, 4'h8, 8'hA0);
        bus(0, 8'hA0, 8'h00);
        chk(got, 8'h11);
        bus(1, 8'h9C, 8'h80);
        bus(0, 8'hA0, 8'h00);
        chk(got, 8'h22);
        bus(1, 8'h9C, 8'hC0);
        bus(0, 8'hA0, 8'h00);
        chk(got, 8'h5A);
        bus(0, 8'hFC, 8'h00);
        chk(got, 8'h00);
        // A reset in mid-run must bring the bus and the status back to idle.
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        chk(8'(wreq), 8'h01);
        rst_n <= 1'b1;
        bus(0, 8'h98, 8'h00);
        chk(got, 8'h00);
        bus(0, 8'h9C, 8'h00);
        chk(got, 8'h00);
        print_verdict();
    end
endmodule
